// >>> logic/pvb_map.svh
/*
 Offsets, field positions, sizes and reset values of the port and system
 variable bank. Assumes byte-wide register addresses on a plain strobe port.
*/
`ifndef PVB_MAP_SVH
`define PVB_MAP_SVH

`define PVB_AW            8
`define PVB_DW            8
`define PVB_NPORT         4
`define PVB_SCR_MAX       1024
`define PVB_SCR_SMALL     128
`define PVB_PTR_W         10

// byte registers
`define PVB_A_PORT        8'h00
`define PVB_A_COPY        8'h01
`define PVB_A_IN0         8'h10
`define PVB_A_DIR0        8'h14
`define PVB_A_OUT0        8'h18
`define PVB_A_PTRL        8'h20
`define PVB_A_PTRH        8'h21
`define PVB_A_AT_PTR      8'h22
`define PVB_A_AT_PTRINC   8'h23
`define PVB_A_AT_PTRDEC   8'h24
`define PVB_A_BPTR        8'h28
`define PVB_A_AT_BPTR     8'h29
`define PVB_A_AT_BPTRINC  8'h2A
`define PVB_A_AT_BPTRDEC  8'h2B
`define PVB_A_FLAGS       8'h30

// single-bit windows, selected by addr[7:5]
`define PVB_W_INBIT       3'h2
`define PVB_W_OUTBIT      3'h3
`define PVB_W_DIRBIT      3'h4
`define PVB_W_PTRBIT      3'h5
`define PVB_W_FLAGBIT     3'h6

// flag bit positions
`define PVB_F_EXT0        0
`define PVB_F_EXT_ANY     3
`define PVB_F_COMP        4
`define PVB_F_RX          5
`define PVB_F_SLAVE_WR    6
`define PVB_F_TOVF        7

// reset values
`define PVB_RST_BYTE      8'h00
`define PVB_RST_PTR       10'h000

`endif

// >>> logic/pvb_pkg.sv
/*
 Types of the port and system variable bank: bus request, hardware events,
 pin groups and the complete state record. Assumes pvb_map.svh is on the
 include path.
*/
`include "pvb_map.svh"

package pvb_pkg;

	typedef struct packed {
		logic [`PVB_AW-1:0] addr;
		logic [`PVB_DW-1:0] wdata;
		logic               wr;
		logic               rd;
	} pvb_req_t;

	typedef struct packed {
		logic rx_done;
		logic slave_write_seen_bit;
		logic timer_ovf;
		logic comp_change;
	} pvb_event_t;

	typedef logic [`PVB_NPORT-1:0][7:0] pvb_port_bytes_t;

	typedef struct packed {
		pvb_port_bytes_t                 pin_meta;
		pvb_port_bytes_t                 pin_sync;
		logic [2:0]                      irq_meta;
		logic [2:0]                      irq_sync;
		logic [2:0]                      irq_prev;
		pvb_port_bytes_t                 out_latch;
		pvb_port_bytes_t                 dir;
		logic [`PVB_PTR_W-1:0]           ptr;
		logic [7:0]                      bptr;
		logic [7:0]                      flags;
		logic [7:0]                      rdata;
		logic [`PVB_SCR_MAX-1:0][7:0]    scr;
	} pvb_state_t;

endpackage

// >>> logic/pvb_bank.sv
/*
 Port and system variable bank: pin ports with output latches and direction
 bits, scratchpad with two pointers and indirect access, system flags.
 Assumes a single 50 MHz clock, pins from outside the clock domain, hardware
 events as one-cycle pulses from logic on the same clock.
*/
//
// Behaviour
// - writing the combined port byte loads the output latch bit for bit.
// - reading the combined port byte returns synchronised input pin levels.
// - copying the port back to itself moves input levels into the latch.
// - eighteen-pin variant reads only input bits 7, 6, 2, 1, 0.
// - larger variants read all eight inputs, each also as single bit.
// - each output bit can be written alone, others untouched.
// - only valid input and output pins exist as bit variables.
// - small-scratchpad variants use an 8-bit pointer with bit access.
// - largest variants use a 10-bit pointer; high byte holds bits 9, 8.
// - indirect access uses the byte at the current pointer.
// - post-increment access transfers the byte, then pointer plus one.
// - post-decrement access transfers the byte, then pointer minus one.
// - largest variants add an 8-bit byte pointer with own indirect access.
// - on large variants each port has a direction register with single-bit writes.
// - largest variants have four ports, each with inputs and directions.
// - a flag bit without hardware use acts as a plain user bit.
// - flag 5 serial receive, flag 6 slave write, flag 7 timer overflow.
// - on small-scratchpad variants flags 0 to 4 have no hardware source.
// - largest variants latch three external interrupts, any-of, comparator.
// - scratchpad spans 128 or 1024 bytes, reached through the pointer.

`include "pvb_map.svh"

module pvb_bank #(
	parameter bit       LARGE    = 1'b1,
	parameter bit [7:0] IN_MASK  = 8'hFF,
	parameter bit [7:0] OUT_MASK = 8'hFF
) (
	// clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	// register port
	input  wire pvb_pkg::pvb_req_t        req,
	output      logic [`PVB_DW-1:0]       rdata,
	// hardware events
	input  wire pvb_pkg::pvb_event_t      ev,
	input  wire logic [2:0]               ext_irq_pin,
	// port pins, A to D
	input  wire pvb_pkg::pvb_port_bytes_t pin_in,
	output      pvb_pkg::pvb_port_bytes_t pin_out,
	output      pvb_pkg::pvb_port_bytes_t pin_oe
);
	import pvb_pkg::*;

	localparam int          NPORT    = LARGE ? `PVB_NPORT : 1;
	localparam int          SCR_SIZE = LARGE ? `PVB_SCR_MAX : `PVB_SCR_SMALL;
	localparam logic [9:0]  PTR_MASK = LARGE ? 10'h3FF : 10'h0FF;
	localparam logic [9:0]  SCR_MASK = 10'(SCR_SIZE - 1);
	// hardware-set flag positions; the rest stay user bits
	localparam logic [7:0]  HW_FLAGS = LARGE ? 8'hFF : 8'hE0;

	pvb_state_t st;
	pvb_state_t next_st;

	// pins
	genvar gp;
	generate
		for (gp = 0; gp < `PVB_NPORT; gp++) begin : g_port
			assign pin_out[gp] = st.out_latch[gp];
			if (gp < NPORT) begin : g_live
				// small parts have fixed outputs, large ones follow direction bits
				assign pin_oe[gp] = LARGE ? (st.dir[gp] & OUT_MASK) : OUT_MASK;
			end else begin : g_absent
				assign pin_oe[gp] = 8'h00;
			end
		end
	endgenerate

	assign rdata = st.rdata;

	always_comb begin
		logic [7:0]  rd_val;
		logic [7:0]  set;
		logic [2:0]  irq_rise;
		logic [1:0]  prt;
		logic [2:0]  bit_i;
		logic [9:0]  pidx;
		logic [9:0]  bidx;
		logic        port_ok;
		rd_val   = 8'h00;
		set      = 8'h00;
		irq_rise = 3'h0;
		prt      = req.addr[4:3];
		bit_i    = req.addr[2:0];
		pidx     = st.ptr & SCR_MASK;
		bidx     = {2'b00, st.bptr} & SCR_MASK;
		port_ok  = 32'(prt) < NPORT;
		next_st  = st;

		// two-stage synchronisers; only the second stage is read
		next_st.pin_meta = pin_in;
		next_st.pin_sync = st.pin_meta;
		next_st.irq_meta = ext_irq_pin;
		next_st.irq_sync = st.irq_meta;
		next_st.irq_prev = st.irq_sync;
		irq_rise = st.irq_sync & ~st.irq_prev;

		// hardware flag sources
		set[`PVB_F_RX]       = ev.rx_done;
		set[`PVB_F_SLAVE_WR] = ev.slave_write_seen_bit;
		set[`PVB_F_TOVF]     = ev.timer_ovf;
		set[`PVB_F_EXT0+2:`PVB_F_EXT0] = irq_rise;
		set[`PVB_F_EXT_ANY]  = |irq_rise;
		set[`PVB_F_COMP]     = ev.comp_change;
		set = set & HW_FLAGS;

		// reads
		if (req.rd) begin
			case (req.addr[7:5])
				`PVB_W_INBIT: begin
					if (port_ok)
						rd_val = {7'h00, st.pin_sync[prt][bit_i] & IN_MASK[bit_i]};
				end
				`PVB_W_OUTBIT: begin
					if (port_ok)
						rd_val = {7'h00, st.out_latch[prt][bit_i]};
				end
				`PVB_W_DIRBIT: begin
					if (port_ok && LARGE)
						rd_val = {7'h00, st.dir[prt][bit_i]};
				end
				`PVB_W_PTRBIT: begin
					if (req.addr[4] && LARGE)
						rd_val = {7'h00, st.bptr[bit_i]};
					else if (!req.addr[4] && req.addr[3:0] < 4'hA)
						rd_val = {7'h00, st.ptr[req.addr[3:0]] & PTR_MASK[req.addr[3:0]]};
				end
				`PVB_W_FLAGBIT: begin
					if (!req.addr[4] && !req.addr[3])
						rd_val = {7'h00, st.flags[bit_i]};
				end
				default: begin
					case (req.addr)
						`PVB_A_PORT:   rd_val = st.pin_sync[0] & IN_MASK;
						`PVB_A_PTRL:   rd_val = st.ptr[7:0];
						`PVB_A_PTRH:   rd_val = {6'h00, st.ptr[9:8] & PTR_MASK[9:8]};
						`PVB_A_AT_PTR,
						`PVB_A_AT_PTRINC,
						`PVB_A_AT_PTRDEC: rd_val = st.scr[pidx];
						`PVB_A_BPTR:   rd_val = LARGE ? st.bptr : 8'h00;
						`PVB_A_AT_BPTR,
						`PVB_A_AT_BPTRINC,
						`PVB_A_AT_BPTRDEC: rd_val = LARGE ? st.scr[bidx] : 8'h00;
						`PVB_A_FLAGS:  rd_val = st.flags;
						default: begin
							if (req.addr[7:4] == 4'h1 && port_ok) begin
								case (req.addr[3:2])
									2'h0: rd_val = st.pin_sync[req.addr[1:0]] & IN_MASK;
									2'h1: rd_val = LARGE ? st.dir[req.addr[1:0]] : 8'h00;
									2'h2: rd_val = st.out_latch[req.addr[1:0]];
									default: rd_val = 8'h00;
								endcase
							end
						end
					endcase
				end
			endcase
		end
		// read data stand for exactly one cycle
		next_st.rdata = rd_val;

		// writes
		if (req.wr) begin
			case (req.addr[7:5])
				`PVB_W_OUTBIT: begin
					if (port_ok && OUT_MASK[bit_i])
						next_st.out_latch[prt][bit_i] = req.wdata[0];
				end
				`PVB_W_DIRBIT: begin
					if (port_ok && LARGE)
						next_st.dir[prt][bit_i] = req.wdata[0];
				end
				`PVB_W_PTRBIT: begin
					if (req.addr[4] && LARGE)
						next_st.bptr[bit_i] = req.wdata[0];
					else if (!req.addr[4] && req.addr[3:0] < 4'hA
						&& PTR_MASK[req.addr[3:0]])
						next_st.ptr[req.addr[3:0]] = req.wdata[0];
				end
				`PVB_W_FLAGBIT: begin
					if (!req.addr[4] && !req.addr[3])
						next_st.flags[bit_i] = req.wdata[0];
				end
				default: begin
					case (req.addr)
						`PVB_A_PORT:
							next_st.out_latch[0] = req.wdata & OUT_MASK;
						`PVB_A_COPY:
							next_st.out_latch[0] = st.pin_sync[0] & IN_MASK & OUT_MASK;
						`PVB_A_PTRL:
							next_st.ptr[7:0] = req.wdata;
						`PVB_A_PTRH: begin
							if (LARGE)
								next_st.ptr[9:8] = req.wdata[1:0];
						end
						`PVB_A_AT_PTR,
						`PVB_A_AT_PTRINC,
						`PVB_A_AT_PTRDEC:
							next_st.scr[pidx] = req.wdata;
						`PVB_A_BPTR: begin
							if (LARGE)
								next_st.bptr = req.wdata;
						end
						`PVB_A_AT_BPTR,
						`PVB_A_AT_BPTRINC,
						`PVB_A_AT_BPTRDEC: begin
							if (LARGE)
								next_st.scr[bidx] = req.wdata;
						end
						`PVB_A_FLAGS:
							next_st.flags = req.wdata;
						default: begin
							if (req.addr[7:4] == 4'h1 && port_ok) begin
								case (req.addr[3:2])
									2'h1: begin
										if (LARGE)
											next_st.dir[req.addr[1:0]] = req.wdata;
									end
									2'h2: next_st.out_latch[req.addr[1:0]] = req.wdata & OUT_MASK;
									default: ;
								endcase
							end
						end
					endcase
				end
			endcase
		end

		// post-increment and post-decrement move the pointer after the transfer
		if (req.wr || req.rd) begin
			case (req.addr)
				`PVB_A_AT_PTRINC:
					next_st.ptr = (st.ptr + 10'h001) & PTR_MASK;
				`PVB_A_AT_PTRDEC:
					next_st.ptr = (st.ptr - 10'h001) & PTR_MASK;
				`PVB_A_AT_BPTRINC: begin
					if (LARGE)
						next_st.bptr = st.bptr + 8'h01;
				end
				`PVB_A_AT_BPTRDEC: begin
					if (LARGE)
						next_st.bptr = st.bptr - 8'h01;
				end
				default: ;
			endcase
		end

		// hardware set wins over a software clear in the same cycle
		next_st.flags = next_st.flags | set;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule // pvb_bank

// >>> verif/pvb_pin_model.sv
/*
 Pin-side model of the port bank: outside levels and interrupt pins.
 Assumes the bench sets the levels; a driven pin reads back its own latch.
*/
module pvb_pin_model
	import pvb_pkg::*;
(
	// bench controls
	input  wire pvb_pkg::pvb_port_bytes_t ext_lvl,
	input  wire logic [2:0]               irq_lvl,
	// bank side
	input  wire pvb_pkg::pvb_port_bytes_t pin_out,
	input  wire pvb_pkg::pvb_port_bytes_t pin_oe,
	output      pvb_pkg::pvb_port_bytes_t pin_in,
	output      logic [2:0]               ext_irq_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// a driven pin shows the bank's level, so the outside value is hidden
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	assign ext_irq_pin = irq_lvl;
endmodule // pvb_pin_model

// >>> verif/pvb_bank_checker.sv
/*
 Assertions on the port bank's register port, events and pins.
 Assumes the large build with open masks; bound to pvb_bank below.
*/
module pvb_bank_checker
	import pvb_pkg::*;
(
	// clock and reset
	input wire logic                     mclk,
	input wire logic                     rst_n,
	// register port and events
	input wire pvb_pkg::pvb_req_t        req,
	input wire logic [7:0]               rdata,
	input wire pvb_pkg::pvb_event_t      ev,
	input wire logic [2:0]               ext_irq_pin,
	// pins
	input wire pvb_pkg::pvb_port_bytes_t pin_in,
	input wire pvb_pkg::pvb_port_bytes_t pin_out,
	input wire pvb_pkg::pvb_port_bytes_t pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// four steady edges cover the two-stage pin synchroniser
	sequence s_steady; $stable(pin_in)[*4]; endsequence
	sequence s_calm; (ev == 4'h0 && $stable(ext_irq_pin))[*6]; endsequence
	sequence s_late_rd; (!req.wr)[*7] ##1 (req.rd && req.addr == 8'h30); endsequence
	property p_port_wr; req.wr && req.addr == 8'h00 |=> pin_out[0] == $past(req.wdata); endproperty
	property p_port_rd;
		s_steady ##0 (req.rd && req.addr == 8'h00) |=> rdata == $past(pin_in[0]);
	endproperty
	property p_copy;
		s_steady ##0 (req.wr && req.addr == 8'h01) |=> pin_out[0] == $past(pin_in[0]);
	endproperty
	property p_in_bit; s_steady ##0 (req.rd && req.addr[7:3] == 5'h08)
		|=> rdata == {7'h00, $past(pin_in[0][req.addr[2:0]])}; endproperty
	property p_out_bit; req.wr && req.addr[7:3] == 5'h0C |=> pin_out[0] ==
		(($past(pin_out[0]) & ~(8'h01 << $past(req.addr[2:0])))
		| (8'($past(req.wdata[0])) << $past(req.addr[2:0]))); endproperty
	property p_dir; req.wr && req.addr[7:2] == 6'h05
		|=> pin_oe[$past(req.addr[1:0])] == $past(req.wdata); endproperty
	property p_ev_flags; ev != 4'h0 ##1 s_late_rd |=> (rdata[7:4] & $past({ev.timer_ovf,
		ev.slave_write_seen_bit, ev.rx_done, ev.comp_change}, 9)) == $past({ev.timer_ovf,
		ev.slave_write_seen_bit, ev.rx_done, ev.comp_change}, 9); endproperty
	property p_ext_flag; $rose(ext_irq_pin[1]) ##1 s_late_rd |=> rdata[1] && rdata[3]; endproperty
	property p_user_flag; s_calm ##0 (req.rd && req.addr == 8'h30 && $past(req.wr, 2)
		&& $past(req.addr, 2) == 8'h30) |=> rdata == $past(req.wdata, 3); endproperty
	a_port_wr: assert property (p_port_wr) else $error("port write not latched");
	a_port_rd: assert property (p_port_rd) else $error("port read not pins");
	a_copy: assert property (p_copy) else $error("copy not taken");
	a_in_bit: assert property (p_in_bit) else $error("input bit wrong");
	a_out_bit: assert property (p_out_bit) else $error("output bit wrong");
	a_dir: assert property (p_dir) else $error("direction wrong");
	a_ev_flags: assert property (p_ev_flags) else $error("event flag lost");
	a_ext_flag: assert property (p_ext_flag) else $error("irq flag lost");
	a_user_flag: assert property (p_user_flag) else $error("user flag lost");
endmodule // pvb_bank_checker

bind pvb_bank pvb_bank_checker u_chk (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
	.ev(ev), .ext_irq_pin(ext_irq_pin), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

// >>> verif/pvb_bank_test.sv
/*
 Self-checking bench for pvb_bank in its large build.
 Assumes the pin model and checker are compiled before it.
*/
module pvb_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pvb_pkg::*;
	logic            mclk;
	logic            rst_n;
	pvb_req_t        req;
	logic [7:0]      rdata;
	pvb_event_t      ev;
	logic [2:0]      ext_irq_pin;
	logic [2:0]      irq_lvl;
	pvb_port_bytes_t pin_in;
	pvb_port_bytes_t pin_out;
	pvb_port_bytes_t pin_oe;
	pvb_port_bytes_t ext_lvl;
	int              err_total;
	int              comparisons;
	int              cycles;
	logic [7:0]      exp_b;

	pvb_bank DUT (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .ev(ev),
		.ext_irq_pin(ext_irq_pin), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	pvb_pin_model u_pins (.ext_lvl(ext_lvl), .irq_lvl(irq_lvl), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in), .ext_irq_pin(ext_irq_pin));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// trailing delay lets the taken write land before any compare
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk) req.wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk) req.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_total++;
			give_verdict();
		end
	end

	initial begin
		rst_n = 1'b0;
		req = '0;
		ev = '0;
		irq_lvl = 3'h0;
		ext_lvl = '0;
		err_total = 0;
		comparisons = 0;
		cycles = 0;
		exp_b = 8'h5A;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(8'h18, 8'h00);
		rd(8'h20, 8'h00);
		rd(8'h30, 8'h00);
		chk(pin_oe[1], 8'h00);
		$display("test reset done");
		wr(8'h00, 8'hC0);
		chk(pin_out[0], 8'hC0);
		@(posedge mclk) ext_lvl[0] <= 8'h5A;
		repeat (4) @(posedge mclk);
		rd(8'h00, 8'h5A);
		wr(8'h01, 8'h00);
		chk(pin_out[0], 8'h5A);
		for (int i = 0; i < 8; i++) rd(8'h40 | 8'(i), {7'h00, exp_b[i]});
		@(posedge mclk) ext_lvl[2] <= 8'h3C;
		repeat (4) @(posedge mclk);
		rd(8'h12, 8'h3C);
		wr(8'h1B, 8'h96);
		chk(pin_out[3], 8'h96);
		chk(pin_oe[0], 8'h00);
		$display("test pins done");
		for (int i = 0; i < 8; i++) begin
			exp_b[i] = ~exp_b[i];
			wr(8'h60 | 8'(i), {7'h00, exp_b[i]});
			chk(pin_out[0], exp_b);
		end
		wr(8'h15, 8'h0F);
		wr(8'h8F, 8'h01);
		chk(pin_oe[1], 8'h8F);
		rd(8'h15, 8'h8F);
		wr(8'h15, 8'h00);
		$display("test outputs done");
		wr(8'h21, 8'h07);
		wr(8'h20, 8'hFF);
		rd(8'h21, 8'h03);
		rd(8'hA9, 8'h01);
		wr(8'h23, 8'hAA);
		wr(8'h22, 8'h55);
		rd(8'h20, 8'h00);
		rd(8'h24, 8'h55);
		rd(8'h22, 8'hAA);
		wr(8'h28, 8'h41);
		wr(8'h2A, 8'h11);
		wr(8'h2A, 8'h22);
		rd(8'h28, 8'h43);
		wr(8'hB0, 8'h00);
		rd(8'h2B, 8'h22);
		rd(8'h29, 8'h11);
		$display("test scratchpad done");
		@(posedge mclk) ev <= '1;
		irq_lvl <= 3'h2;
		@(posedge mclk) ev <= '0;
		repeat (6) @(posedge mclk);
		rd(8'h30, 8'hFA);
		wr(8'h30, 8'h00);
		rd(8'h30, 8'h00);
		wr(8'hC2, 8'h01);
		rd(8'h30, 8'h04);
		wr(8'h30, 8'h00);
		@(posedge mclk) irq_lvl <= 3'h7;
		repeat (4) @(posedge mclk);
		rd(8'h30, 8'h0D);
		wr(8'h3F, 8'hFF);
		rd(8'h3F, 8'h00);
		$display("test flags done");
		give_verdict();
	end
endmodule // pvb_bank_test
